// ==== logic/fmsp_pkg.sv ====
package fmsp_pkg;

   // ****************************************
   // Register word indices (byte address is index times 4)
   // ****************************************
   localparam logic [7:0] FMSP_CTRL_HIGH_IDX = 8'hfc;
   localparam logic [7:0] FMSP_CTRL_LOW_IDX = 8'hfd;
   localparam logic [7:0] FMSP_DATA_IDX = 8'hfe;
   localparam logic [7:0] FMSP_BAUD_IDX = 8'hff;
   localparam logic [7:0] FMSP_IRQ_IDX = 8'hf0;
   localparam logic [7:0] FMSP_FLAG_IDX = 8'hf1;
   localparam int FMSP_ADDR_W = 12;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int FMSP_MCE_BIT = 5;
   localparam int FMSP_RXEN_BIT = 4;
   localparam int FMSP_TB8_BIT = 3;
   localparam int FMSP_RB8_BIT = 2;
   localparam int FMSP_AUTOPAR_BIT = 7;
   localparam int FMSP_TXODD_BIT = 6;
   localparam int FMSP_RXODD_BIT = 5;
   localparam int FMSP_PERR_BIT = 4;
   localparam int FMSP_TXIRQ_BIT = 3;
   localparam int FMSP_RXIRQ_BIT = 4;
   localparam int FMSP_TXFLAG_BIT = 0;
   localparam int FMSP_RXFLAG_BIT = 1;
   localparam logic [7:0] FMSP_REG_RST = 8'h00;
   localparam logic [3:0] FMSP_TICKS_PER_BIT = 4'hf;
   localparam logic [3:0] FMSP_MID_TICK = 4'h7;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      FMSP_MODE_SYNC,
      FMSP_MODE_ASYNC8,
      FMSP_MODE_ASYNC9_FIXED,
      FMSP_MODE_ASYNC9_VAR
   } fmsp_mode_t;

   typedef struct packed {
      logic sel;
      logic en;
      logic wr;
      logic [FMSP_ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } fmsp_apb_req_t;

   typedef struct packed {
      logic txd;
      logic rxd_out;
      logic rxd_oe;
   } fmsp_pins_t;

endpackage

// ==== logic/fmsp_serial_port.sv ====
// Chosen here: the APB slave port.
`timescale 1ns/10ps
module fmsp_serial_port
   import fmsp_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [FMSP_ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Interrupt handshake
   input wire logic tx_irq_ack_i,
   input wire logic rx_irq_ack_i,
   output logic tx_irq_request_o,
   output logic rx_irq_request_o,
   // Serial pins
   input wire logic rxd_i,
   output logic txd_o,
   output logic rxd_out_o,
   output logic rxd_oe_o
);

   // ****************************************
   // Input synchroniser and bus decode
   // ****************************************
   logic rxd_meta_reg, rxd_sync_reg, rxd_prev_reg;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rxd_meta_reg <= 1'b1;
         rxd_sync_reg <= 1'b1;
         rxd_prev_reg <= 1'b1;
      end else if (ce_i) begin
         rxd_meta_reg <= rxd_i;
         rxd_sync_reg <= rxd_meta_reg;
         rxd_prev_reg <= rxd_sync_reg;
      end
   end

   fmsp_apb_req_t req;
   assign req = '{sel: psel_i, en: penable_i, wr: pwrite_i, addr: paddr_i, wdata: pwdata_i};
   logic acc, wr_acc, rd_acc, hit;
   logic [7:0] word_addr;
   assign acc = req.sel && req.en && !pready_o && ce_i;
   assign wr_acc = acc && req.wr;
   assign rd_acc = acc && !req.wr;
   assign word_addr = req.addr[9:2];
   assign hit = (req.addr[FMSP_ADDR_W-1:10] == '0) && (req.addr[1:0] == 2'b00) &&
                (word_addr inside {FMSP_CTRL_HIGH_IDX, FMSP_CTRL_LOW_IDX, FMSP_DATA_IDX,
                                   FMSP_BAUD_IDX, FMSP_IRQ_IDX, FMSP_FLAG_IDX});

   // ****************************************
   // Control registers
   // ****************************************
   fmsp_mode_t mode_reg;
   logic mce_reg, rxen_reg, tb8_reg, rb8_reg;
   logic autopar_reg, txodd_reg, rxodd_reg, perr_reg;
   logic [1:0] clksel_reg;
   logic [7:0] baud_reg, txbuf_reg, rxbuf_reg;
   logic tx_flag_reg, rx_flag_reg;
   logic tx_done, rx_done, rx_irq_ok, rx_perr, rx_rb8;
   logic [7:0] rx_byte;
   logic tx_load, rx_start_sync;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         mode_reg <= FMSP_MODE_SYNC;
         mce_reg <= 1'b0;
         tb8_reg <= 1'b0;
         autopar_reg <= 1'b0;
         txodd_reg <= 1'b0;
         rxodd_reg <= 1'b0;
         clksel_reg <= 2'b00;
         baud_reg <= FMSP_REG_RST;
         txbuf_reg <= FMSP_REG_RST;
      end else if (wr_acc) begin
         case (word_addr)
            FMSP_CTRL_HIGH_IDX: begin
               mode_reg <= fmsp_mode_t'(req.wdata[7:6]);
               mce_reg <= req.wdata[FMSP_MCE_BIT];
               tb8_reg <= req.wdata[FMSP_TB8_BIT];
            end
            FMSP_CTRL_LOW_IDX: begin
               autopar_reg <= req.wdata[FMSP_AUTOPAR_BIT];
               txodd_reg <= req.wdata[FMSP_TXODD_BIT];
               rxodd_reg <= req.wdata[FMSP_RXODD_BIT];
               clksel_reg <= req.wdata[3:2];
            end
            FMSP_DATA_IDX: txbuf_reg <= req.wdata[7:0];
            FMSP_BAUD_IDX: baud_reg <= req.wdata[7:0];
            default: ;
         endcase
      end
   end

   assign tx_load = wr_acc && (word_addr == FMSP_DATA_IDX);
   assign rx_start_sync = wr_acc && (word_addr == FMSP_CTRL_HIGH_IDX) &&
                          req.wdata[FMSP_RXEN_BIT] &&
                          (req.wdata[7:6] == 2'b00);

   // Receive enable; mode 0 reception clears it when done
   logic sync_rx_done;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rxen_reg <= 1'b0;
      end else if (wr_acc && word_addr == FMSP_CTRL_HIGH_IDX) begin
         rxen_reg <= req.wdata[FMSP_RXEN_BIT];
      end else if (ce_i && sync_rx_done) begin
         rxen_reg <= 1'b0;
      end
   end

   // Received data, ninth bit and parity status
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rxbuf_reg <= FMSP_REG_RST;
         rb8_reg <= 1'b0;
         perr_reg <= 1'b0;
      end else if (ce_i && rx_done) begin
         rxbuf_reg <= rx_byte;
         if (mode_reg[1]) begin
            rb8_reg <= rx_rb8;
            perr_reg <= rx_perr;
         end
      end
   end

   // ****************************************
   // Requests and status flags
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         tx_irq_request_o <= 1'b0;
         rx_irq_request_o <= 1'b0;
      end else if (ce_i) begin
         if (tx_done) begin
            tx_irq_request_o <= 1'b1;
         end else if (tx_irq_ack_i || (wr_acc && word_addr == FMSP_IRQ_IDX &&
                                       !req.wdata[FMSP_TXIRQ_BIT])) begin
            tx_irq_request_o <= 1'b0;
         end
         if (rx_done && rx_irq_ok) begin
            rx_irq_request_o <= 1'b1;
         end else if (rx_irq_ack_i || (wr_acc && word_addr == FMSP_IRQ_IDX &&
                                       !req.wdata[FMSP_RXIRQ_BIT])) begin
            rx_irq_request_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         tx_flag_reg <= 1'b0;
         rx_flag_reg <= 1'b0;
      end else if (ce_i) begin
         if (tx_done) begin
            tx_flag_reg <= 1'b1;
         end else if (wr_acc && word_addr == FMSP_FLAG_IDX && !req.wdata[FMSP_TXFLAG_BIT]) begin
            tx_flag_reg <= 1'b0;
         end
         if (rx_done && rx_irq_ok) begin
            rx_flag_reg <= 1'b1;
         end else if (wr_acc && word_addr == FMSP_FLAG_IDX && !req.wdata[FMSP_RXFLAG_BIT]) begin
            rx_flag_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // APB read and answer
   // ****************************************
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      case (word_addr)
         FMSP_CTRL_HIGH_IDX: rd_mux = {mode_reg, mce_reg, rxen_reg, tb8_reg, rb8_reg, 2'b00};
         FMSP_CTRL_LOW_IDX: rd_mux = {autopar_reg, txodd_reg, rxodd_reg, perr_reg,
                                      clksel_reg, 2'b00};
         FMSP_DATA_IDX: rd_mux = rxbuf_reg;
         FMSP_BAUD_IDX: rd_mux = baud_reg;
         FMSP_IRQ_IDX: rd_mux = {3'b000, rx_irq_request_o, tx_irq_request_o, 3'b000};
         FMSP_FLAG_IDX: rd_mux = {6'h00, rx_flag_reg, tx_flag_reg};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else if (ce_i) begin
         pready_o <= req.sel && req.en && !pready_o;
         pslverr_o <= req.sel && req.en && !pready_o && !hit;
         prdata_o <= (rd_acc && hit) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      end
   end

   // ****************************************
   // Baud tick generation
   // ****************************************
   logic [2:0] pre_cnt_reg;
   logic [7:0] baud_cnt_reg;
   logic src_tick, tick;
   logic [7:0] eff_div;
   always_comb begin
      case (clksel_reg)
         2'b00: src_tick = (pre_cnt_reg == 3'h7);
         2'b01: src_tick = (pre_cnt_reg[1:0] == 2'h3);
         2'b10: src_tick = pre_cnt_reg[0];
         default: src_tick = 1'b1;
      endcase
   end
   assign eff_div = (mode_reg == FMSP_MODE_ASYNC9_FIXED) ? 8'h00 : baud_reg;
   assign tick = src_tick && (baud_cnt_reg == eff_div);

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pre_cnt_reg <= 3'h0;
         baud_cnt_reg <= 8'h00;
      end else if (ce_i) begin
         pre_cnt_reg <= pre_cnt_reg + 3'h1;
         if (src_tick) begin
            baud_cnt_reg <= (baud_cnt_reg >= eff_div) ? 8'h00 : baud_cnt_reg + 8'h01;
         end
      end
   end

   // ****************************************
   // Transmitter
   // ****************************************
   logic tx_busy_reg;
   logic [3:0] tx_sub_reg, tx_bit_reg;
   logic [10:0] tx_sh_reg;
   logic tx_ninth;
   logic [3:0] tx_last;
   assign tx_ninth = autopar_reg ? (^req.wdata[7:0] ^ txodd_reg) : tb8_reg;
   assign tx_last = (mode_reg == FMSP_MODE_SYNC) ? 4'd7 :
                    (mode_reg == FMSP_MODE_ASYNC8) ? 4'd9 : 4'd10;
   assign tx_done = tx_busy_reg && tick && tx_sub_reg == FMSP_TICKS_PER_BIT &&
                    ((mode_reg == FMSP_MODE_SYNC) ? (tx_bit_reg == 4'd7) :
                     (tx_bit_reg == tx_last - 4'd1));

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         tx_busy_reg <= 1'b0;
         tx_sub_reg <= 4'h0;
         tx_bit_reg <= 4'h0;
         tx_sh_reg <= 11'h7ff;
      end else if (ce_i) begin
         if (tx_load && !tx_busy_reg) begin
            tx_busy_reg <= 1'b1;
            tx_sub_reg <= 4'h0;
            tx_bit_reg <= 4'h0;
            case (mode_reg)
               FMSP_MODE_SYNC: tx_sh_reg <= {3'b111, req.wdata[7:0]};
               FMSP_MODE_ASYNC8: tx_sh_reg <= {2'b11, req.wdata[7:0], 1'b0};
               default: tx_sh_reg <= {1'b1, tx_ninth, req.wdata[7:0], 1'b0};
            endcase
         end else if (tx_busy_reg && tick) begin
            tx_sub_reg <= tx_sub_reg + 4'h1;
            if (tx_sub_reg == FMSP_TICKS_PER_BIT) begin
               tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
               tx_bit_reg <= tx_bit_reg + 4'h1;
               if (tx_bit_reg == tx_last) begin
                  tx_busy_reg <= 1'b0;
               end
            end
         end
      end
   end

   // ****************************************
   // Receiver
   // ****************************************
   typedef enum logic [1:0] {RX_IDLE, RX_SYNC, RX_ASYNC} fmsp_rx_state_t;
   fmsp_rx_state_t rx_state_reg;
   logic [3:0] rx_sub_reg, rx_bit_reg;
   logic [8:0] rx_sh_reg;
   logic rx_last_sample, rx_sample;
   assign rx_sample = tick && rx_sub_reg == FMSP_MID_TICK;
   // Last sample: stop bit in mode 1, ninth bit in modes 2 and 3
   assign rx_last_sample = rx_state_reg == RX_ASYNC && rx_sample && rx_bit_reg == 4'd9;
   assign sync_rx_done = rx_state_reg == RX_SYNC && tick &&
                         rx_sub_reg == FMSP_TICKS_PER_BIT && rx_bit_reg == 4'd7;
   assign rx_done = sync_rx_done || rx_last_sample;
   // Eight data samples sit above the start or stale bit in every mode
   assign rx_byte = rx_sh_reg[8:1];
   assign rx_rb8 = rxd_sync_reg;
   assign rx_perr = (^rx_sh_reg[8:1] ^ rxd_sync_reg) != rxodd_reg;
   always_comb begin
      case (mode_reg)
         FMSP_MODE_SYNC: rx_irq_ok = 1'b1;
         FMSP_MODE_ASYNC8: rx_irq_ok = !mce_reg || rxd_sync_reg;
         default: rx_irq_ok = !mce_reg || rxd_sync_reg;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rx_state_reg <= RX_IDLE;
         rx_sub_reg <= 4'h0;
         rx_bit_reg <= 4'h0;
         rx_sh_reg <= 9'h000;
      end else if (ce_i) begin
         case (rx_state_reg)
            RX_IDLE: begin
               rx_sub_reg <= 4'h0;
               rx_bit_reg <= 4'h0;
               if (rx_start_sync) begin
                  rx_state_reg <= RX_SYNC;
               end else if (rxen_reg && mode_reg != FMSP_MODE_SYNC &&
                            rxd_prev_reg && !rxd_sync_reg) begin
                  rx_state_reg <= RX_ASYNC;
               end
            end
            RX_SYNC: if (tick) begin
               rx_sub_reg <= rx_sub_reg + 4'h1;
               if (rx_sample) begin
                  rx_sh_reg <= {rxd_sync_reg, rx_sh_reg[8:1]};
               end
               if (rx_sub_reg == FMSP_TICKS_PER_BIT) begin
                  rx_bit_reg <= rx_bit_reg + 4'h1;
                  if (rx_bit_reg == 4'd7) begin
                     rx_state_reg <= RX_IDLE;
                  end
               end
            end
            RX_ASYNC: if (tick) begin
               rx_sub_reg <= rx_sub_reg + 4'h1;
               if (rx_sample) begin
                  rx_sh_reg <= {rxd_sync_reg, rx_sh_reg[8:1]};
                  if (rx_bit_reg == 4'd0 && rxd_sync_reg) begin
                     rx_state_reg <= RX_IDLE;
                  end
                  if (rx_bit_reg == 4'd9) begin
                     rx_state_reg <= RX_IDLE;
                  end
               end
               if (rx_sub_reg == FMSP_TICKS_PER_BIT) begin
                  rx_bit_reg <= rx_bit_reg + 4'h1;
               end
            end
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
   end

   // ****************************************
   // Pin drivers
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         txd_o <= 1'b1;
         rxd_out_o <= 1'b1;
         rxd_oe_o <= 1'b0;
      end else if (ce_i) begin
         if (mode_reg == FMSP_MODE_SYNC) begin
            // Shift clock low in first half of each bit
            txd_o <= !((tx_busy_reg || rx_state_reg == RX_SYNC) &&
                       !(tx_sub_reg[3] | rx_sub_reg[3]));
            rxd_out_o <= tx_sh_reg[0];
            rxd_oe_o <= tx_busy_reg;
         end else begin
            txd_o <= tx_busy_reg ? tx_sh_reg[0] : 1'b1;
            rxd_out_o <= 1'b1;
            rxd_oe_o <= 1'b0;
         end
      end
   end

endmodule

// ==== verif/fmsp_remote_model.sv ====
`timescale 1ns/10ps
module fmsp_remote_model (
   // Clock
   input wire logic clk_i,
   // Device pins
   input wire logic txd_i,
   input wire logic dat_i,
   output logic rxd_o
);
   initial rxd_o = 1'b1;
   // ******
   // Asynchronous frames
   // ******
   task automatic send(input logic [8:0] d, input int nb, input int per, input logic stp);
      logic [10:0] f;
      f = {stp, d, 1'b0};
      if (nb == 8) f[9] = stp;
      for (int i = 0; i <= nb + 1; i++) begin
         rxd_o <= f[i];
         repeat (per) @(posedge clk_i);
      end
      rxd_o <= 1'b1;
      repeat (per) @(posedge clk_i);
   endtask
   task automatic recv(output logic [8:0] d, output logic stp, input int nb, input int per);
      d = 9'h0;
      stp = 1'b0;
      while (txd_i !== 1'b0) @(posedge clk_i);
      repeat (per / 2) @(posedge clk_i);
      for (int i = 0; i <= nb; i++) begin
         repeat (per) @(posedge clk_i);
         if (i < nb) d[i] = txd_i;
         else stp = txd_i;
      end
   endtask
   // ******
   // Synchronous shift peripheral
   // ******
   task automatic m0_out(output logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         @(posedge txd_i);
         d[i] = dat_i;
      end
   endtask
   task automatic m0_in(input logic [7:0] d, input int per);
      for (int i = 0; i < 8; i++) begin
         @(negedge txd_i);
         rxd_o <= d[i];
      end
      repeat (per) @(posedge clk_i);
      rxd_o <= 1'b1;
   endtask
endmodule

// ==== verif/fmsp_serial_port_sva.sv ====
`timescale 1ns/10ps
module fmsp_serial_port_sva
   import fmsp_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // APB
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [FMSP_ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // Interrupts and pins
   input wire logic tx_irq_ack_i,
   input wire logic rx_irq_ack_i,
   input wire logic tx_irq_request_o,
   input wire logic rx_irq_request_o,
   input wire logic txd_o,
   input wire logic rxd_oe_o
);
   // ******
   // Configuration snoop
   // ******
   localparam logic [11:0] A_HI = {2'h0, FMSP_CTRL_HIGH_IDX, 2'h0};
   localparam logic [11:0] A_LO = {2'h0, FMSP_CTRL_LOW_IDX, 2'h0};
   localparam logic [11:0] A_DT = {2'h0, FMSP_DATA_IDX, 2'h0};
   localparam logic [11:0] A_BD = {2'h0, FMSP_BAUD_IDX, 2'h0};
   localparam logic [11:0] A_IQ = {2'h0, FMSP_IRQ_IDX, 2'h0};
   logic tk;
   logic wq;
   logic [1:0] mode_reg;
   logic [1:0] cs_reg;
   logic [7:0] bd_reg;
   assign tk = psel_i && penable_i && !pready_o && ce_i && pwrite_i;
   assign wq = tk && paddr_i == A_IQ;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         mode_reg <= 2'h0;
         cs_reg <= 2'h0;
         bd_reg <= 8'h0;
      end else if (tk) begin
         if (paddr_i == A_HI) mode_reg <= pwdata_i[7:6];
         if (paddr_i == A_LO) cs_reg <= pwdata_i[3:2];
         if (paddr_i == A_BD) bd_reg <= pwdata_i[7:0];
      end
   end
   // ******
   // Properties
   // ******
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   ans_a:
      assert property (psel_i && penable_i && !pready_o && ce_i |=> pready_o ##1 !pready_o)
      else $error("apb answer not a one cycle pulse");
   err_a:
      assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
      else $error("error response malformed");
   txack_a:
      assert property (tx_irq_ack_i |-> ##[1:2] !tx_irq_request_o)
      else $error("tx request not cleared by ack");
   rxack_a:
      assert property (rx_irq_ack_i |-> ##[1:2] !rx_irq_request_o)
      else $error("rx request not cleared by ack");
   txhold_a:
      assert property (tx_irq_request_o && !tx_irq_ack_i && !$past(tx_irq_ack_i) && !wq
         && !$past(wq) |=> tx_irq_request_o)
      else $error("tx request dropped");
   rxhold_a:
      assert property (rx_irq_request_o && !rx_irq_ack_i && !$past(rx_irq_ack_i) && !wq
         && !$past(wq) |=> rx_irq_request_o)
      else $error("rx request dropped");
   stopreq_a:
      assert property ($rose(tx_irq_request_o) && mode_reg != 2'h0 |=> txd_o)
      else $error("tx request outside stop bit");
   oemode_a:
      assert property (rxd_oe_o |-> mode_reg == 2'h0)
      else $error("data pin driven outside mode 0");
   tx0_a:
      assert property (tk && paddr_i == A_DT && mode_reg == 2'h0 && cs_reg == 2'h3
         && bd_reg == 8'h0 && !rxd_oe_o && txd_o |-> ##[1:20] !txd_o)
      else $error("mode 0 shift did not start");
   rx0_a:
      assert property (tk && paddr_i == A_HI && pwdata_i[7:4] == 4'h1 && cs_reg == 2'h3
         && bd_reg == 8'h0 |-> ##[1:20] !txd_o)
      else $error("mode 0 receive clock did not start");
endmodule
bind fmsp_serial_port fmsp_serial_port_sva u_sva (.clk_i(clk_i), .resetn_i(resetn_i),
   .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .tx_irq_ack_i(tx_irq_ack_i), .rx_irq_ack_i(rx_irq_ack_i),
   .tx_irq_request_o(tx_irq_request_o), .rx_irq_request_o(rx_irq_request_o),
   .txd_o(txd_o), .rxd_oe_o(rxd_oe_o));

// ==== verif/fmsp_serial_port_tb.sv ====
`timescale 1ns/10ps
module fmsp_serial_port_tb
   import fmsp_pkg::*;
;
   logic clk;
   logic resetn;
   fmsp_apb_req_t bus;
   logic tx_ack;
   logic rx_ack;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic tx_req;
   logic rx_req;
   logic txd;
   logic rxd_out;
   logic rxd_oe;
   logic mdl_rxd;
   wire rxd_wire;
   int fail_count = 0;
   int samples_checked = 0;
   logic [7:0] rxlo [4] = '{8'h0c, 8'h0c, 8'h2c, 8'h2c};
   logic [8:0] rxf [4] = '{9'h033, 9'h031, 9'h031, 9'h131};
   logic [3:0] perr = 4'b1010;
   assign rxd_wire = rxd_oe ? rxd_out : mdl_rxd;
   fmsp_serial_port DUT (.clk_i(clk), .resetn_i(resetn), .ce_i(1'b1), .psel_i(bus.sel),
      .penable_i(bus.en), .pwrite_i(bus.wr), .paddr_i(bus.addr), .pwdata_i(bus.wdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .tx_irq_ack_i(tx_ack),
      .rx_irq_ack_i(rx_ack), .tx_irq_request_o(tx_req), .rx_irq_request_o(rx_req),
      .rxd_i(rxd_wire), .txd_o(txd), .rxd_out_o(rxd_out), .rxd_oe_o(rxd_oe));
   fmsp_remote_model MDL (.clk_i(clk), .txd_i(txd), .dat_i(rxd_out), .rxd_o(mdl_rxd));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ******
   // Tasks
   // ******
   function automatic logic [11:0] ad(input logic [7:0] i);
      return {2'h0, i, 2'h0};
   endfunction
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("[FAIL] %s exp %h got %h", nm, exp, got);
         fail_count++;
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge clk);
      bus <= '{sel: 1'b1, en: 1'b0, wr: w, addr: a, wdata: {24'h0, d}};
      @(posedge clk);
      bus.en <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      bus.sel <= 1'b0;
      bus.en <= 1'b0;
      chk("pready", 32'h1, {31'h0, pready});
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, ad(i), d, r, e);
   endtask
   task automatic rd(input logic [7:0] i, input logic [31:0] exp, input string nm);
      logic [31:0] r;
      logic e;
      apb(1'b0, ad(i), 8'h0, r, e);
      chk(nm, exp, r);
   endtask
   task automatic wait_req(input logic rx);
      int n;
      n = 0;
      while ((rx ? rx_req : tx_req) !== 1'b1 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      chk("request", 32'h1, {31'h0, rx ? rx_req : tx_req});
   endtask
   task automatic ack(input logic rx);
      @(posedge clk);
      if (rx) rx_ack <= 1'b1;
      else tx_ack <= 1'b1;
      @(posedge clk);
      rx_ack <= 1'b0;
      tx_ack <= 1'b0;
      repeat (2) @(posedge clk);
      chk("ack clear", 32'h0, {31'h0, rx ? rx_req : tx_req});
   endtask
   task automatic tx_frame(input logic [7:0] d, input int nb, input int per,
      input logic [8:0] exp);
      logic [8:0] got;
      logic stp;
      fork
         MDL.recv(got, stp, nb, per);
         wr(FMSP_DATA_IDX, d);
      join
      chk("tx frame", {23'h0, exp}, {23'h0, got});
      chk("tx stop", 32'h1, {31'h0, stp});
      chk("tx request", 32'h1, {31'h0, tx_req});
      ack(1'b0);
      repeat (per) @(posedge clk);
   endtask
   task automatic test_done();
      if (fail_count == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ******
   // Sequence
   // ******
   initial begin
      logic [7:0] m0;
      logic [31:0] r;
      logic e;
      bus = '0;
      resetn = 1'b0;
      tx_ack = 1'b0;
      rx_ack = 1'b0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      rd(FMSP_BAUD_IDX, {24'h0, FMSP_REG_RST}, "baud reset");
      apb(1'b0, 12'h000, 8'h0, r, e);
      chk("unmapped", 32'h1, {31'h0, e});
      wr(FMSP_CTRL_HIGH_IDX, 8'h04);
      rd(FMSP_CTRL_HIGH_IDX, 32'h0, "ninth rx ro");
      wr(FMSP_CTRL_LOW_IDX, 8'h10);
      rd(FMSP_CTRL_LOW_IDX, 32'h0, "perr ro");
      wr(FMSP_CTRL_HIGH_IDX, 8'h40);
      for (int cs = 0; cs < 4; cs++) begin
         wr(FMSP_CTRL_LOW_IDX, 8'(cs << 2));
         wr(FMSP_BAUD_IDX, 8'(cs));
         tx_frame(8'h5a ^ 8'(cs), 8, 16 * (8 >> cs) * (cs + 1), {1'b0, 8'h5a ^ 8'(cs)});
      end
      wr(FMSP_CTRL_HIGH_IDX, 8'h88);
      tx_frame(8'h07, 9, 16, 9'h107);
      wr(FMSP_CTRL_LOW_IDX, 8'hcc);
      tx_frame(8'h07, 9, 16, 9'h007);
      wr(FMSP_CTRL_LOW_IDX, 8'h8c);
      tx_frame(8'h03, 9, 16, 9'h003);
      wr(FMSP_BAUD_IDX, 8'h01);
      wr(FMSP_CTRL_HIGH_IDX, 8'hd0);
      for (int i = 0; i < 4; i++) begin
         wr(FMSP_CTRL_LOW_IDX, rxlo[i]);
         MDL.send(rxf[i], 9, 32, 1'b1);
         wait_req(1'b1);
         rd(FMSP_DATA_IDX, {24'h0, rxf[i][7:0]}, "rx data");
         rd(FMSP_CTRL_HIGH_IDX, {24'h0, 8'hd0 | {5'h0, rxf[i][8], 2'h0}}, "rx ninth");
         rd(FMSP_CTRL_LOW_IDX, {24'h0, rxlo[i] | {3'h0, perr[i], 4'h0}}, "parity");
         ack(1'b1);
      end
      apb(1'b0, ad(FMSP_FLAG_IDX), 8'h0, r, e);
      chk("rx flag", 32'h1, {31'h0, r[FMSP_RXFLAG_BIT]});
      wr(FMSP_CTRL_HIGH_IDX, 8'hf0);
      MDL.send(9'h1a5, 9, 32, 1'b1);
      wait_req(1'b1);
      ack(1'b1);
      MDL.send(9'h0a5, 9, 32, 1'b1);
      chk("mce filter", 32'h0, {31'h0, rx_req});
      wr(FMSP_CTRL_HIGH_IDX, 8'h70);
      MDL.send(9'h055, 8, 32, 1'b0);
      chk("stop filter", 32'h0, {31'h0, rx_req});
      MDL.send(9'h055, 8, 32, 1'b1);
      wait_req(1'b1);
      ack(1'b1);
      wr(FMSP_CTRL_HIGH_IDX, 8'hc8);
      tx_frame(8'h3c, 9, 32, 9'h13c);
      rd(FMSP_DATA_IDX, 32'h55, "rx kept");
      wr(FMSP_CTRL_HIGH_IDX, 8'h00);
      wr(FMSP_BAUD_IDX, 8'h00);
      wr(FMSP_FLAG_IDX, 8'h00);
      rd(FMSP_FLAG_IDX, 32'h0, "flags cleared");
      fork
         MDL.m0_out(m0);
         wr(FMSP_DATA_IDX, 8'h96);
      join
      wait_req(1'b0);
      chk("m0 tx", 32'h96, {24'h0, m0});
      rd(FMSP_FLAG_IDX, 32'h1, "tx flag");
      ack(1'b0);
      fork
         MDL.m0_in(8'h6b, 16);
         wr(FMSP_CTRL_HIGH_IDX, 8'h10);
      join
      wait_req(1'b1);
      rd(FMSP_DATA_IDX, 32'h6b, "m0 rx");
      rd(FMSP_FLAG_IDX, 32'h3, "rx flag");
      ack(1'b1);
      test_done();
   end
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      test_done();
   end
endmodule
